// File: smr_link_model.sv
// Remote serial slave that clocks bytes into the receive path
`timescale 1ns/1ps
module smr_link_model (
    output logic sclLine,  // Serial clock, parked high between frames
    output logic sdaRel    // Data drive, 1 means released to pull-up
);
    // Idle bus: clock stands still, data left to the pull-up
    initial begin
        sclLine = 1'h1;
        sdaRel  = 1'h1;
    end

    // One byte MSB first, 400 ns a bit; data moves mid-low phase
    task automatic send_byte(input logic [7:0] val);
        #13;
        for (int i = 7; i >= 0; i--) begin
            sclLine = 1'h0;
            #100;
            sdaRel = val[i];
            #100;
            sclLine = 1'h1;
            #200;
        end
        // Release data so no stale bit lingers after the frame
        #100;
        sdaRel = 1'h1;
        #100;
    endtask : send_byte
endmodule : smr_link_model

// File: smr_pkg.sv
// Constants and types of the serial master receive path
package smr_pkg;
    // Register byte addresses
    localparam logic [15:0] ADR_CTRL1  = 16'hF078;
    localparam logic [15:0] ADR_STAT   = 16'hF07C;
    localparam logic [15:0] ADR_TXBUF  = 16'hF07E;
    localparam logic [15:0] ADR_RXBUF  = 16'hF07F;
    localparam logic [15:0] ADR_IRQST  = 16'hF070;
    localparam logic [15:0] ADR_IRQMSK = 16'hF071;
    localparam logic [15:0] ADR_FMT    = 16'hF072;
    // Field positions in serial_control_one
    localparam int B_RXOFF = 6;
    localparam int B_MSEL  = 5;
    localparam int B_TRS  = 4;
    // Field positions in serial_status
    localparam int B_TXE  = 7;
    localparam int B_RXF  = 5;
    localparam int B_OVE  = 2;
    // Field positions in the format register
    localparam int B_SYNC  = 0;
    localparam int B_START = 1;
    // Interrupt status and mask bits
    localparam int I_RX  = 0;
    localparam int I_TX  = 1;
    localparam int I_OVE = 2;
    // Values after reset
    localparam logic [7:0] RST_RXBUF = 8'hFF;
    localparam logic [7:0] RST_TXBUF = 8'hFF;
    // Last bit index of a byte frame
    localparam logic [2:0] LAST_BIT = 3'h7;

    // Operating mode, one-hot
    typedef enum logic [3:0] {
        MODE_SRX = 4'h1,
        MODE_STX = 4'h2,
        MODE_MRX = 4'h4,
        MODE_MTX = 4'h8
    } smr_mode_t;

    // Register port request
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } smr_bus_t;

    // Whole block state
    typedef struct packed {
        logic [2:0] sclSync;
        logic [2:0] sdaSync;
        logic       sclLvl;
        logic       sdaLvl;
        logic       rxOff;
        logic       masterSel;
        logic       trs;
        logic       sync;
        logic       txEmpty;
        logic       rxFull;
        logic       ove;
        logic       seenTxEmpty;
        logic       seenRxFull;
        logic       seenOve;
        logic [7:0] txBuf;
        logic       txFull;
        logic [7:0] rxBuf;
        logic [7:0] shift;
        logic [2:0] bitCnt;
        logic       rxBlock;
        logic [2:0] irqSt;
        logic [2:0] irqMask;
        logic [7:0] rdData;
        logic       irq;
        logic       sdaOe;
        smr_mode_t  mode;
    } smr_state_t;

    // Reset image of the state
    localparam smr_state_t ST_RST = '{
        sclSync: 3'h7, sdaSync: 3'h7, sclLvl: 1'h1, sdaLvl: 1'h1,
        txBuf: RST_TXBUF, rxBuf: RST_RXBUF, mode: MODE_SRX,
        default: '0};
endpackage : smr_pkg

// File: smr_rx_path.sv
// Serial master receive path: registers, flags and shift engine
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
// Behaviour
// - rxbuf read with TRS 0: disable blocks next
// - select,TRS 00/01/10 give SRX/STX/MRX
// - select,TRS 11 gives master transmit
// - I2C arbitration loss clears select and TRS
// - tx empty set: tx load, TRS set, start
// - tx empty cleared by write-0-after-1 or tx write
// - rx full set when byte enters rxbuf
// - rx full cleared by rxbuf read or write-0-after-1
// - sync: final bit while rx full sets OVE
// - OVE cleared only by write-0-after-1
// - complete byte copied shift to rxbuf
// - rxbuf read-only, resets to all ones
module smr_rx_path
    import smr_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire smr_bus_t   busIn,
    output logic [7:0]      rdData,
    output logic            irq,
    output smr_mode_t       opMode,
    input  wire logic       sclIn,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe
);
    smr_state_t state_reg;   // Registered state
    smr_state_t state_next;  // Next state
    logic       sclRise;     // Filtered serial clock rose
    logic       sclFall;     // Filtered serial clock fell
    logic       byteDone;    // Final bit of a byte sampled
    logic       rxAccept;    // Byte moves into rxbuf
    logic       arbLost;     // Master lost the bus
    logic       evRx;        // RECEIVE_FULL_FLAG set event
    logic       evTx;        // TRANSMIT_EMPTY_FLAG set event
    logic       evOv;        // OVE set event
    logic [7:0] shiftIn;     // Shift value after sampling
    logic       wrCtrl;      // Write to control one
    logic       rdRx;        // Read of rxbuf

    // Outputs straight from the state flops, except sdaOut, which is tied low
    assign rdData = state_reg.rdData;
    assign irq    = state_reg.irq;
    assign opMode = state_reg.mode;
    assign sdaOe  = state_reg.sdaOe;
    assign sdaOut = 1'b0;  // Open drain: only ever pulls low

    // Next-state logic for the whole block
    always_comb begin
        state_next = state_reg;
        sclRise    = 1'b0;
        sclFall    = 1'b0;
        byteDone   = 1'b0;
        rxAccept   = 1'b0;
        arbLost    = 1'b0;
        evRx       = 1'b0;
        evTx       = 1'b0;
        evOv       = 1'b0;
        shiftIn    = {state_reg.shift[6:0], state_reg.sdaLvl};
        wrCtrl     = busIn.wr && busIn.addr == ADR_CTRL1;
        rdRx       = busIn.rd && busIn.addr == ADR_RXBUF;
        state_next.rdData = 8'h00;

        // Three-flop synchronisers; level moves when stages 2 and 3 agree
        state_next.sclSync = {state_reg.sclSync[1:0], sclIn};
        state_next.sdaSync = {state_reg.sdaSync[1:0], sdaIn};
        if (state_reg.sclSync[1] == state_reg.sclSync[2]) begin
            state_next.sclLvl = state_reg.sclSync[2];
        end
        if (state_reg.sdaSync[1] == state_reg.sdaSync[2]) begin
            state_next.sdaLvl = state_reg.sdaSync[2];
        end
        sclRise = !state_reg.sclLvl && state_next.sclLvl;
        sclFall = state_reg.sclLvl && !state_next.sclLvl;

        // Register reads; data appear in the next cycle
        if (busIn.rd) begin
            case (busIn.addr)
                ADR_CTRL1: begin
                    state_next.rdData[B_RXOFF] = state_reg.rxOff;
                    state_next.rdData[B_MSEL]  = state_reg.masterSel;
                    state_next.rdData[B_TRS]  = state_reg.trs;
                end
                ADR_STAT: begin
                    // Remember flags seen as 1 for write-0 clearing
                    state_next.rdData[B_TXE] = state_reg.txEmpty;
                    state_next.rdData[B_RXF] = state_reg.rxFull;
                    state_next.rdData[B_OVE] = state_reg.ove;
                    if (state_reg.txEmpty) state_next.seenTxEmpty = 1'b1;
                    if (state_reg.rxFull)  state_next.seenRxFull  = 1'b1;
                    if (state_reg.ove)  state_next.seenOve  = 1'b1;
                end
                ADR_RXBUF: begin
                    state_next.rdData = state_reg.rxBuf;
                    state_next.rxFull     = 1'b0;
                    state_next.seenRxFull = 1'b0;
                    // Receive mode: disable bit decides the next byte
                    if (!state_reg.trs) begin
                        state_next.rxBlock = state_reg.rxOff;
                    end
                end
                ADR_TXBUF:  state_next.rdData = state_reg.txBuf;
                ADR_IRQST: begin
                    // Read clears; new events below still win
                    state_next.rdData[2:0] = state_reg.irqSt;
                    state_next.irqSt = 3'h0;
                end
                ADR_IRQMSK: state_next.rdData[2:0] = state_reg.irqMask;
                ADR_FMT: state_next.rdData[B_SYNC] = state_reg.sync;
                default:    state_next.rdData = 8'h00;
            endcase
        end

        // Register writes
        if (busIn.wr) begin
            case (busIn.addr)
                ADR_CTRL1: begin
                    state_next.rxOff     = busIn.wdata[B_RXOFF];
                    state_next.masterSel = busIn.wdata[B_MSEL];
                    state_next.trs  = busIn.wdata[B_TRS];
                    // Rising TRS marks the transmit buffer empty
                    if (busIn.wdata[B_TRS] && !state_reg.trs) begin
                        evTx = 1'b1;
                    end
                end
                ADR_STAT: begin
                    // Writing 1 leaves a flag alone
                    if (!busIn.wdata[B_TXE] && state_reg.seenTxEmpty) begin
                        state_next.txEmpty     = 1'b0;
                        state_next.seenTxEmpty = 1'b0;
                    end
                    if (!busIn.wdata[B_RXF] && state_reg.seenRxFull) begin
                        state_next.rxFull     = 1'b0;
                        state_next.seenRxFull = 1'b0;
                    end
                    if (!busIn.wdata[B_OVE] && state_reg.seenOve) begin
                        state_next.ove     = 1'b0;
                        state_next.seenOve = 1'b0;
                    end
                end
                ADR_TXBUF: begin
                    state_next.txBuf    = busIn.wdata;
                    state_next.txFull      = 1'b1;
                    state_next.txEmpty     = 1'b0;
                    state_next.seenTxEmpty = 1'b0;
                end
                ADR_IRQMSK: state_next.irqMask = busIn.wdata[2:0];
                ADR_FMT: begin
                    state_next.sync = busIn.wdata[B_SYNC];
                    // Issuing a start empties the transmit side
                    if (busIn.wdata[B_START]) evTx = 1'b1;
                end
                // Receive buffer ignores writes
                ADR_RXBUF:  state_next.rxBuf = state_reg.rxBuf;
                default:    state_next.rdData = state_next.rdData;
            endcase
        end

        // Shift engine, sampling on serial clock rise
        if (sclRise) begin
            // Released SDA seen low: someone else owns the bus
            if (!state_reg.sync && state_reg.masterSel && state_reg.trs &&
                !state_reg.sdaOe && !state_reg.sdaLvl) begin
                arbLost = 1'b1;
            end
            state_next.shift  = shiftIn;
            state_next.bitCnt = state_reg.bitCnt + 3'h1;
            byteDone = state_reg.bitCnt == LAST_BIT;
        end

        // Received byte hand-off
        if (byteDone && !state_reg.trs) begin
            if (state_reg.rxFull) begin
                // Unread byte still held; new one is lost
                if (state_reg.sync) evOv = 1'b1;
            end else if (!state_reg.rxBlock) begin
                rxAccept = 1'b1;
                state_next.rxBuf = shiftIn;
                evRx = 1'b1;
            end
        end

        // Transmit drive on serial clock fall
        if (sclFall && state_reg.trs) begin
            if (state_reg.bitCnt == 3'h0) begin
                if (state_reg.txFull) begin
                    state_next.shift  = state_reg.txBuf;
                    state_next.txFull = 1'b0;
                    state_next.sdaOe  = !state_reg.txBuf[7];
                    evTx = 1'b1;
                end else begin
                    state_next.sdaOe = 1'b0;
                end
            end else begin
                state_next.sdaOe = !state_reg.shift[7];
            end
        end
        if (!state_next.trs) state_next.sdaOe = 1'b0;

        // Lost arbitration drops to slave receive
        if (arbLost) begin
            state_next.masterSel = 1'b0;
            state_next.trs    = 1'b0;
            state_next.sdaOe  = 1'b0;
            state_next.bitCnt = 3'h0;
            evOv = 1'b1;
        end

        // Set events win over same-cycle clears
        if (evRx) state_next.rxFull  = 1'b1;
        if (evTx) state_next.txEmpty = 1'b1;
        if (evOv) state_next.ove  = 1'b1;
        state_next.irqSt = state_next.irqSt | {evOv, evTx, evRx};

        // Mode decode from the two selection bits
        case ({state_next.masterSel, state_next.trs})
            2'h0:    state_next.mode = MODE_SRX;
            2'h1:    state_next.mode = MODE_STX;
            2'h2:    state_next.mode = MODE_MRX;
            2'h3:    state_next.mode = MODE_MTX;
            default: state_next.mode = MODE_SRX;
        endcase

        // Level interrupt while any unmasked event is pending
        state_next.irq = |(state_next.irqSt & state_next.irqMask);
    end

    // State register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ST_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // Checks on the flag and mode behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // Byte received into an empty, unblocked buffer
    sequence sRxDone;
        byteDone && !state_reg.trs && !state_reg.rxFull && !state_reg.rxBlock;
    endsequence

    // Buffer read while the disable bit asks to stop
    sequence sBlockSet;
        rdRx && !state_reg.trs && state_reg.rxOff;
    endsequence

    // Byte completing while reception is blocked
    sequence sRxRefused;
        byteDone && !state_reg.trs && !state_reg.rxFull && state_reg.rxBlock;
    endsequence

    a_rxfull_on_byte: assert property (
        sRxDone |=> state_reg.rxFull && state_reg.rxBuf == $past(shiftIn))
        else $error("Full flag or rxbuf not updated on byte");
    a_rxfull_read_clr: assert property (
        rdRx && !evRx |=> !state_reg.rxFull)
        else $error("Full flag not cleared by rxbuf read");
    a_ove_on_overrun: assert property (
        byteDone && !state_reg.trs && state_reg.sync && state_reg.rxFull
        |=> state_reg.ove && $stable(state_reg.rxBuf))
        else $error("Overrun not flagged");
    a_ove_hold: assert property (
        state_reg.ove && !(busIn.wr && busIn.addr == ADR_STAT &&
        !busIn.wdata[B_OVE]) |=> state_reg.ove)
        else $error("OVE cleared without write of 0");
    a_txempty_on_trs: assert property (
        wrCtrl && busIn.wdata[B_TRS] && !state_reg.trs |=> state_reg.txEmpty)
        else $error("Empty flag not set by TRS rising");
    a_txempty_tx_clr: assert property (
        busIn.wr && busIn.addr == ADR_TXBUF && !evTx |=> !state_reg.txEmpty)
        else $error("Empty flag not cleared by tx write");
    a_mode_master_rx: assert property (
        wrCtrl && busIn.wdata[B_MSEL:B_TRS] == 2'h2 && !arbLost
        |=> opMode == MODE_MRX)
        else $error("Master receive mode not selected");
    a_mode_master_tx: assert property (
        wrCtrl && busIn.wdata[B_MSEL:B_TRS] == 2'h3 && !arbLost
        |=> opMode == MODE_MTX)
        else $error("Master transmit mode not selected");
    a_arb_to_slave: assert property (
        arbLost |=> opMode == MODE_SRX && !state_reg.sdaOe)
        else $error("Arbitration loss did not enter slave receive");
    a_arb_flag: assert property (
        arbLost |=> state_reg.ove)
        else $error("Arbitration loss not flagged");
    a_rx_blocked: assert property (
        sBlockSet |=> state_reg.rxBlock)
        else $error("Reception not blocked by disable bit");
    a_rx_refused: assert property (
        sRxRefused |=> $stable(state_reg.rxBuf) && !state_reg.rxFull)
        else $error("Blocked byte reached rxbuf");
    a_rxbuf_readonly: assert property (
        busIn.wr && busIn.addr == ADR_RXBUF && !rxAccept
        |=> $stable(state_reg.rxBuf))
        else $error("Write changed rxbuf");
endmodule : smr_rx_path

// File: test_serial_master_receive_path.sv
// Self-checking bench for the serial master receive path
`timescale 1ns/1ps
module test_serial_master_receive_path
    import smr_pkg::*;
;
    logic        clk;           // Module clock
    logic        arst_n;        // Async reset, low active
    smr_bus_t    busIn;         // Register port request
    logic [7:0]  rdData;        // Read data
    logic        irq;           // Interrupt level
    smr_mode_t   opMode;        // Decoded mode
    logic        sclLine;       // Link clock from the slave
    logic        sdaRel;        // Slave data drive
    logic        sdaOut;        // Device data value, always low
    logic        sdaOe;         // Device pulls data low
    wire logic   sdaWire = sdaRel & ~sdaOe; // Open-drain wire level
    int          num_errors;    // Mismatches
    int          total_checks;  // Comparisons made
    int          cycles;        // Watchdog count
    logic [31:0] rng;           // Xorshift state
    logic [7:0]  bytes [6];     // Random payloads
    logic [7:0]  rxQ [$];       // Model: bytes that reached rxbuf
    int          fullM;         // Model: unread byte held
    int          offM;          // Model: next reception refused
    int          syncM;         // Model: synchronous format
    int          oveM;          // Model: overrun flag

    // Free-running 20 MHz clock
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    smr_rx_path dut (
        .clk    (clk),
        .arst_n (arst_n),
        .busIn  (busIn),
        .rdData (rdData),
        .irq    (irq),
        .opMode (opMode),
        .sclIn  (sclLine),
        .sdaIn  (sdaWire),
        .sdaOut (sdaOut),
        .sdaOe  (sdaOe)
    );

    smr_link_model slave (
        .sclLine (sclLine),
        .sdaRel  (sdaRel)
    );

    // Payload generator with a fixed seed
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    // Single comparison point
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One-cycle write strobe
    task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        busIn.addr  <= a;
        busIn.wdata <= d;
        busIn.wr    <= 1'h1;
        @(posedge clk);
        busIn.wr    <= 1'h0;
    endtask : bus_wr

    // One-cycle read; data looked at only in the following cycle
    task automatic bus_rd(input logic [15:0] a, input logic [7:0] exp,
                          input string what);
        @(posedge clk);
        busIn.addr <= a;
        busIn.rd   <= 1'h1;
        @(posedge clk);
        busIn.rd   <= 1'h0;
        #1;
        check(what, rdData, exp);
    endtask : bus_rd

    // Whole frame from the slave, then time for the sync stages
    task automatic rx(input logic [7:0] b);
        @(posedge clk);
        slave.send_byte(b);
        repeat (8) @(posedge clk);
        // Model: full buffer refuses, overrun only in sync format
        if (fullM != 0) begin
            oveM = oveM | syncM;
        end else if (offM == 0) begin
            rxQ.push_back(b);
            fullM = 1;
        end
    endtask : rx

    // Buffer read against the model; sets the refusal state too
    task automatic rd_rx(input int off, input string what);
        bus_rd(ADR_RXBUF, rxQ[$], what);
        fullM = 0;
        offM  = off;
    endtask : rd_rx

    // Counts, verdict and end of run
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    // Watchdog: the whole sequence needs under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            give_verdict();
        end
    end

    // Main sequence
    initial begin
        num_errors   = 0;
        total_checks = 0;
        cycles       = 0;
        fullM        = 0;
        offM         = 0;
        syncM        = 0;
        oveM         = 0;
        rxQ.push_back(RST_RXBUF);
        rng          = 32'h5A1114B3;
        busIn        = '0;
        arst_n       = 1'h0;
        for (int i = 0; i < 6; i++) begin
            rng      = xorshift(rng);
            bytes[i] = rng[7:0];
        end
        repeat (5) @(posedge clk);
        arst_n <= 1'h1;
        // Reset image; receive buffer ignores writes
        bus_rd(ADR_RXBUF, 8'hFF, "rxbuf reset");
        bus_wr(ADR_RXBUF, 8'h00);
        bus_rd(ADR_RXBUF, 8'hFF, "rxbuf write");
        bus_rd(ADR_STAT, 8'h00, "status reset");
        bus_rd(16'hF000, 8'h00, "unmapped");
        // Every mode code, changed only between frames
        for (int m = 0; m < 4; m++) begin
            bus_wr(ADR_CTRL1, 8'(m << 4));
            #100;
            check("mode", 8'(opMode), 8'(1 << m));
        end
        bus_wr(ADR_CTRL1, 8'h20);
        bus_rd(ADR_STAT, 8'h80, "empty on trs");
        bus_wr(ADR_STAT, 8'h7F);
        bus_rd(ADR_STAT, 8'h00, "empty write zero");
        check("irq masked", {7'h0, irq}, 8'h00);
        bus_rd(ADR_IRQST, 8'h02, "irq tx event");
        bus_wr(ADR_IRQMSK, 8'h07);
        // Byte cleared by reading the buffer
        rx(bytes[0]);
        bus_rd(ADR_STAT, 8'(fullM << B_RXF), "full set");
        check("irq raised", {7'h0, irq}, 8'h01);
        bus_rd(ADR_IRQST, 8'h01, "irq rx event");
        #100;
        check("irq cleared", {7'h0, irq}, 8'h00);
        rd_rx(0, "rx byte");
        bus_rd(ADR_STAT, 8'h00, "full read clear");
        // Byte cleared by zero written after a read of one
        rx(bytes[1]);
        bus_rd(ADR_STAT, 8'(fullM << B_RXF), "full again");
        bus_wr(ADR_STAT, 8'hDF);
        fullM = 0;
        bus_rd(ADR_STAT, 8'h00, "full write clear");
        // Overrun in synchronous format; unread flag resists a clear
        bus_wr(ADR_FMT, 8'h01);
        syncM = 1;
        rx(bytes[2]);
        rx(bytes[3]);
        bus_wr(ADR_STAT, 8'hFB);
        bus_rd(ADR_STAT, 8'((fullM << B_RXF) | (oveM << B_OVE)),
               "overrun set");
        bus_rd(ADR_IRQST, 8'h05, "irq rx ove");
        bus_wr(ADR_STAT, 8'hFB);
        oveM = 0;
        bus_rd(ADR_STAT, 8'(fullM << B_RXF), "overrun clear");
        rd_rx(0, "first kept");
        // Reception blocked by the disable bit, then let through
        bus_wr(ADR_CTRL1, 8'h60);
        rd_rx(1, "block read");
        rx(bytes[4]);
        bus_rd(ADR_STAT, 8'(fullM << B_RXF), "blocked");
        bus_wr(ADR_CTRL1, 8'h20);
        rd_rx(0, "unblock read");
        rx(bytes[5]);
        rd_rx(0, "after unblock");
        // Empty-flag sources, then arbitration lost on the first bit
        bus_wr(ADR_CTRL1, 8'h30);
        bus_rd(ADR_STAT, 8'h80, "empty trs set");
        bus_wr(ADR_TXBUF, 8'hFF);
        bus_rd(ADR_STAT, 8'h00, "empty tx write");
        bus_wr(ADR_FMT, 8'h02);
        syncM = 0;
        bus_rd(ADR_STAT, 8'h80, "empty start");
        bus_wr(ADR_TXBUF, 8'hFF);
        // Slave holds data low; the lost byte never reaches rxbuf
        @(posedge clk);
        slave.send_byte(8'h00);
        repeat (8) @(posedge clk);
        bus_rd(ADR_STAT, 8'h84, "arb lost flag");
        check("arb lost mode", 8'(opMode), 8'(MODE_SRX));
        check("data released", {6'h0, sdaOut, sdaOe}, 8'h00);
        give_verdict();
    end
endmodule : test_serial_master_receive_path
